// ---- pkg/reading_buffer_params.svh ----
// Constants of the reading storage buffer
`ifndef READING_BUFFER_PARAMS_SVH
`define READING_BUFFER_PARAMS_SVH
`define RB_CAP_MIN        12'h002
`define RB_CAP_MAX        12'h9C4
`define RB_CAP_RESET      12'h064
`define RB_CAP_W          12
`define RB_DATA_W         32
`define RB_STAMP_W        48
`define RB_DAY_SEC        17'h15180
`define RB_CLK_HZ         125000000
`define RB_SEC_CYCLES     (`RB_CLK_HZ)
`define RB_FIFO_DEPTH     4
`endif

// ---- pkg/reading_buffer_pkg.sv ----
// Types of the reading storage buffer
package reading_buffer_pkg;
  typedef enum logic [1:0] {
    FILL_ONCE  = 2'h0,
    FILL_WRAP  = 2'h1,
    fill_a     = 2'h2
  } fill_mode_t;
  typedef struct packed {
    logic [31:0] value;
    logic [47:0] absolute_stamp;
    logic [16:0] relative_stamp;
  } entry_t;
endpackage : reading_buffer_pkg

// ---- rtl/stage_fifo.sv ----
// Small valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
module stage_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] memReg [DEPTH];
  logic [AW-1:0]    wrReg;
  logic [AW-1:0]    rdReg;
  logic [AW:0]      cntReg;
  logic             push;
  logic             pop;
  logic [AW:0]      cntNext;

  assign cntNext  = cntReg + (AW+1)'(push) - (AW+1)'(pop);
  assign outValid = (cntReg != '0);
  assign outData  = memReg[rdReg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      memReg[wrReg] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrReg  <= '0;
      rdReg  <= '0;
      cntReg <= '0;
      inReady <= 1'b1;
    end else begin
      if (push) begin
        wrReg <= (wrReg == AW'(DEPTH-1)) ? '0 : wrReg + AW'(1);
      end
      if (pop) begin
        rdReg <= (rdReg == AW'(DEPTH-1)) ? '0 : rdReg + AW'(1);
      end
      cntReg  <= cntNext;
      inReady <= (cntNext != (AW+1)'(DEPTH));
    end
  end
endmodule : stage_fifo

// ---- rtl/reading_buffer_store.sv ----
// Reading storage buffer with fill modes, capacity and time stamps
//
// Contract
// (R1) Source selects raw reading or post-math result; raw stored even with math on (code stores only the selected source, math value alone when math is on).
// (R2) Fill-once: after capacity stored, discard later readings, fill_a overwrite.
// (R3) Continuous: wrap to first location, newest replaces oldest.
// (R4) No-fill mode stores nothing.
// (R5) Capacity between 2 and 2500 inclusive; controller must not exceed range.
// (R6) Configured capacity is readable back.
// (R7) Relative time counts from the first stored reading.
// (R8) Relative time restarts at zero every 24 hours.
// (R9) Absolute stamp taken from real-time clock at storage.
// (R10) Live count of held readings is readable.
// (R11) Reset gives wrap mode, raw source, capacity 100.
`timescale 1ns/1ps
`include "reading_buffer_params.svh"
module reading_buffer_store #(
  parameter int DEPTH      = 2500,
  parameter int SEC_CYCLES = `RB_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst,
  // Measurement pipeline
  input  wire logic                              rawValid,
  input  wire logic [`RB_DATA_W-1:0]             rawValue,
  input  wire logic                              mathValid,
  input  wire logic [`RB_DATA_W-1:0]             mathValue,
  output logic                                   feedReady,
  // Real-time clock
  input  wire logic [`RB_STAMP_W-1:0]            rtcNow,
  // Configuration
  input  wire logic                              cfgWrite,
  input  wire logic                              post_math_source,
  input  wire reading_buffer_pkg::fill_mode_t    fillMode,
  input  wire logic [`RB_CAP_W-1:0]              capacity_cmd,
  // Read port
  input  wire logic [`RB_CAP_W-1:0]              rdIndex,
  output reading_buffer_pkg::entry_t             rdEntry,
  // Status
  output logic [`RB_CAP_W-1:0]                   capacityOut,
  output logic [`RB_CAP_W-1:0]                   countOut,
  output reading_buffer_pkg::fill_mode_t         modeOut,
  output logic                                   sourceOut,
  output logic                                   fullOut
);
  // ==========================================================
  // Configuration
  reading_buffer_pkg::fill_mode_t modeReg;
  logic                           srcReg;
  logic [`RB_CAP_W-1:0]           capReg;

  always_ff @(posedge clk) begin
    if (rst) begin
      modeReg <= reading_buffer_pkg::FILL_WRAP;                 // R11
      srcReg  <= 1'b0;                                          // R11
      capReg  <= `RB_CAP_RESET;                                 // R11
    end else if (cfgWrite) begin
      modeReg <= fillMode;
      srcReg  <= post_math_source;                              // R1
      if (capacity_cmd >= `RB_CAP_MIN && capacity_cmd <= `RB_CAP_MAX) begin
        capReg <= capacity_cmd;                                 // R5
      end
    end
  end

  // ==========================================================
  // Source selection into FIFO
  logic                         selValid;
  logic [`RB_DATA_W-1:0]        selValue;
  logic                         fifoValid;
  logic [`RB_DATA_W-1:0]        fifoValue;
  logic                         fifoPop;

  assign selValid = srcReg ? mathValid : rawValid;              // R1
  assign selValue = srcReg ? mathValue : rawValue;              // R1

  stage_fifo #(.WIDTH(`RB_DATA_W), .DEPTH(`RB_FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (selValid),
    .inReady  (feedReady),
    .inData   (selValue),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoValue)
  );

  // ==========================================================
  // Relative time since first stored reading
  logic [31:0]     tickReg;
  logic [16:0]     secReg;
  logic            runReg;
  logic            storeEn;

  always_ff @(posedge clk) begin
    if (rst) begin
      tickReg <= 32'h0000_0000;
      secReg  <= 17'h0_0000;
      runReg  <= 1'b0;
    end else if (!runReg) begin
      if (storeEn) begin
        runReg  <= 1'b1;                                        // R7
        tickReg <= 32'h0000_0001;
      end
    end else if (tickReg == 32'(SEC_CYCLES - 1)) begin
      tickReg <= 32'h0000_0000;
      secReg  <= (secReg == `RB_DAY_SEC - 17'h0_0001) ? 17'h0_0000 : secReg + 17'h0_0001; // R8
    end else begin
      tickReg <= tickReg + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Storage and write pointer
  reading_buffer_pkg::entry_t memReg [DEPTH];
  logic [`RB_CAP_W-1:0]       wrReg;
  logic [`RB_CAP_W-1:0]       cntReg;
  logic                       fullNow;

  assign fullNow = (cntReg >= capReg);
  assign storeEn = fifoValid && (modeReg == reading_buffer_pkg::FILL_WRAP ||
                   (modeReg == reading_buffer_pkg::FILL_ONCE && !fullNow)); // R2 R4
  assign fifoPop = fifoValid;                                   // R2

  always_ff @(posedge clk) begin
    if (storeEn) begin
      memReg[wrReg] <= '{value: fifoValue, absolute_stamp: rtcNow,           // R9
                         relative_stamp: runReg ? secReg : 17'h0_0000};    // R7
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrReg  <= '0;
      cntReg <= '0;
    end else if (storeEn) begin
      wrReg <= (wrReg + 12'h001 >= capReg) ? '0 : wrReg + 12'h001;      // R3
      if (!fullNow) begin
        cntReg <= cntReg + 12'h001;
      end
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      rdEntry     <= '0;
      capacityOut <= `RB_CAP_RESET;
      countOut    <= '0;
      modeOut     <= reading_buffer_pkg::FILL_WRAP;
      sourceOut   <= 1'b0;
      fullOut     <= 1'b0;
    end else begin
      rdEntry     <= memReg[rdIndex];
      capacityOut <= capReg;                                    // R6
      countOut    <= (cntReg > capReg) ? capReg : cntReg;       // R10
      modeOut     <= modeReg;
      sourceOut   <= srcReg;
      fullOut     <= fullNow;
    end
  end
endmodule : reading_buffer_store

// ---- dv/reading_buffer_store_assertions.sv ----
// Status port checker of the reading buffer
`timescale 1ns/1ps
`include "reading_buffer_params.svh"
module reading_buffer_store_assertions (
  // Clock and reset
  input wire logic                           clk,
  input wire logic                           rst,
  // Configuration and read inputs
  input wire logic                           cfgWrite,
  input wire logic                           post_math_source,
  input wire reading_buffer_pkg::fill_mode_t fillMode,
  input wire logic [`RB_CAP_W-1:0]           capacity_cmd,
  input wire logic [`RB_CAP_W-1:0]           rdIndex,
  // Status and read outputs
  input wire logic                           sourceOut,
  input wire logic                           fullOut,
  input wire reading_buffer_pkg::fill_mode_t modeOut,
  input wire logic [`RB_CAP_W-1:0]           capacityOut,
  input wire logic [`RB_CAP_W-1:0]           countOut,
  input wire reading_buffer_pkg::entry_t     rdEntry
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_reset_state: assert property ($fell(rst) |-> capacityOut == `RB_CAP_RESET && countOut == 12'h000
    && modeOut == reading_buffer_pkg::FILL_WRAP && !sourceOut) else $error("bad state after reset");
  chk_cap_read: assert property (cfgWrite && capacity_cmd >= `RB_CAP_MIN && capacity_cmd <= `RB_CAP_MAX
    |=> ##1 capacityOut == $past(capacity_cmd, 2)) else $error("capacity not taken");
  chk_cap_refuse: assert property (cfgWrite && (capacity_cmd < `RB_CAP_MIN || capacity_cmd > `RB_CAP_MAX)
    ##1 !cfgWrite |=> $stable(capacityOut)) else $error("bad capacity taken");
  chk_mode_read: assert property (cfgWrite |=> ##1 modeOut == $past(fillMode, 2))
    else $error("mode not taken");
  chk_source_read: assert property (cfgWrite |=> ##1 sourceOut == $past(post_math_source, 2))
    else $error("source not taken");
  chk_count_bound: assert property (countOut <= capacityOut) else $error("count above capacity");
  chk_count_step: assert property (countOut <= $past(countOut) + 12'h001) else $error("count jumped");
  chk_once_hold: assert property ((modeOut == reading_buffer_pkg::FILL_ONCE && fullOut) [*3]
    |=> $stable(countOut)) else $error("full buffer changed");
  chk_nofill_hold: assert property ((modeOut == reading_buffer_pkg::fill_a) [*4] |=> $stable(countOut))
    else $error("no-fill stored");
  chk_rel_bound: assert property ($past(rdIndex) < countOut |-> rdEntry.relative_stamp < `RB_DAY_SEC)
    else $error("relative stamp past a day");
endmodule : reading_buffer_store_assertions
bind reading_buffer_store reading_buffer_store_assertions i_chk (.clk, .rst, .cfgWrite, .post_math_source,
  .sourceOut, .fullOut, .fillMode, .modeOut, .capacity_cmd, .capacityOut, .countOut, .rdIndex, .rdEntry);

// ---- dv/meas_feed_model.sv ----
// Measurement pipeline model: one raw and one math reading per request
`timescale 1ns/1ps
module meas_feed_model (
  // Request
  input wire logic        clk,
  input wire logic        fire,
  input wire logic [31:0] value,
  // Readings
  output logic            rawValid,
  output logic            mathValid,
  output logic [31:0]     rawValue,
  output logic [31:0]     mathValue
);
  initial {rawValid, mathValid, rawValue, mathValue} = '0;
  // Idle data lines toggle so stale values are fill_a mistaken for readings
  always @(posedge clk) begin
    rawValid  <= fire;
    mathValid <= fire;
    rawValue  <= fire ? value : ~rawValue;
    mathValue <= fire ? ~value : ~mathValue;
  end
endmodule : meas_feed_model

// ---- dv/tb_top.sv ----
// Self-checking bench of the reading buffer
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin numErrors++; $display("[ERR] %0t got %h", $time, a); end end
module tb_top;
  logic clk = 0, rst = 1, fire = 0, cfgWrite = 0, src = 0, rawValid, mathValid, feedReady, sourceOut, fullOut;
  logic [31:0] rawValue, mathValue, value = '0;
  logic [47:0] rtcNow = '0;
  logic [11:0] cap = '0, rdIndex = '0, capacityOut, countOut;
  reading_buffer_pkg::fill_mode_t mode = reading_buffer_pkg::FILL_ONCE, modeOut;
  reading_buffer_pkg::entry_t rdEntry;
  int numErrors = 0, checksDone = 0, cycles = 0;
  always #4 clk = ~clk;
  meas_feed_model i_feed (.clk, .fire, .value, .rawValid, .rawValue, .mathValid, .mathValue);
  reading_buffer_store #(.SEC_CYCLES(4)) i_dut (.clk, .rst, .rawValid, .rawValue, .mathValid, .mathValue,
    .feedReady, .rtcNow, .cfgWrite, .post_math_source(src), .fillMode(mode), .capacity_cmd(cap), .rdIndex,
    .rdEntry, .capacityOut, .countOut, .modeOut, .sourceOut, .fullOut);
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic reset_dut;
    @(posedge clk);
    rst <= 1;
    tick(10);
    rst <= 0;
    tick(1);
    #1;
  endtask : reset_dut
  task automatic set_cfg(logic s, reading_buffer_pkg::fill_mode_t m, logic [11:0] c);
    @(posedge clk);
    {src, mode, cap, cfgWrite} <= {s, m, c, 1'b1};
    @(posedge clk);
    cfgWrite <= 0;
    tick(2);
    #1;
  endtask : set_cfg
  task automatic put(logic [31:0] v, logic [47:0] t, int gap);
    @(posedge clk);
    {value, rtcNow, fire} <= {v, t, 1'b1};
    @(posedge clk);
    fire <= 0;
    tick(gap);
    #1;
  endtask : put
  task automatic entry(logic [11:0] i, logic [31:0] v);
    @(posedge clk);
    rdIndex <= i;
    tick(2);
    #1;
    `CHK(rdEntry.value, v)
  endtask : entry
  task automatic finish_test;
    $display("errors %0d checks %0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      numErrors++;
      finish_test();
    end
  end
  initial begin
    reset_dut();
    `CHK({capacityOut, modeOut, sourceOut}, {12'h064, reading_buffer_pkg::FILL_WRAP, 1'b0})
    `CHK({fullOut, feedReady}, 2'b01)
    set_cfg(0, reading_buffer_pkg::FILL_ONCE, 12'h002);
    `CHK(capacityOut, 12'h002)
    put(32'h0000_0011, 48'h00A5_0000_1234, 13);
    `CHK(countOut, 12'h001)
    put(32'h0000_0022, 48'h00A5_0000_5678, 1);
    put(32'h0000_0033, 48'h00A5_0000_9ABC, 5);
    `CHK({countOut, fullOut}, {12'h002, 1'b1})
    entry(12'h000, 32'h0000_0011);
    `CHK({rdEntry.absolute_stamp, rdEntry.relative_stamp}, {48'h00A5_0000_1234, 17'h00000})
    entry(12'h001, 32'h0000_0022);
    `CHK({rdEntry.absolute_stamp, rdEntry.relative_stamp}, {48'h00A5_0000_5678, 17'h00003})
    reset_dut();
    `CHK(countOut, 12'h000)
    set_cfg(1, reading_buffer_pkg::FILL_WRAP, 12'h002);
    put(32'h0000_0005, 48'h0, 0);
    put(32'h0000_0006, 48'h0, 0);
    put(32'h0000_0007, 48'h0, 5);
    `CHK({countOut, sourceOut}, {12'h002, 1'b1})
    entry(12'h000, ~32'h0000_0007);
    entry(12'h001, ~32'h0000_0006);
    set_cfg(0, reading_buffer_pkg::fill_a, 12'h9C5);
    `CHK({capacityOut, modeOut}, {12'h002, reading_buffer_pkg::fill_a})
    put(32'h0000_0009, 48'h0, 6);
    `CHK(countOut, 12'h002)
    entry(12'h001, ~32'h0000_0006);
    set_cfg(0, reading_buffer_pkg::FILL_ONCE, 12'h9C4);
    `CHK(capacityOut, 12'h9C4)
    set_cfg(0, reading_buffer_pkg::FILL_WRAP, 12'h001);
    `CHK(capacityOut, 12'h9C4)
    finish_test();
  end
endmodule : tb_top
